//--- ctu_params.svh
/*
 Counter/timer unit constants: divisors and pin positions.
 Assumes inclusion by bare name.
*/
// What this block does
// - six 16-bit timers: two classic, four auto-reload
// - timers 0/1: 13-bit, 16-bit, 8-bit reload; timer 0 also split mode
// - timers 2/3 run as one 16-bit or two 8-bit auto-reload timers
// - timers 4/5 do 16-bit reload, capture, and a half-duty toggle output
// - timers 0/1 pick system clock or prescaled clock from shared prescale field
// - timers 2/3 clocked by system clock, clock/12 or external oscillator/8
// - timers 4/5 clocked by clock, clock/2, clock/12 or oscillator/8
// - counter mode increments once per falling edge on the selected input pin
// - synchronous sampling counts events up to a quarter of clock
// - split mode: low byte uses timer 0 run, gate, select and flag
// - split low byte counts clock ticks or pin events per timer 0 select
// - split high byte only times, on clock or prescale, never pin events
// - split high byte runs on timer 1 run bit and sets timer 1 flag
// - in split, timer 1 takes no external clock and sets no flag
// - in split, timer 1 overflow still goes out as baud and trigger tick
// - in split, timer 1 runs in modes 0, 1, 2 and stops in mode 3
// - timer 1 mode field: 00 is 13-bit, 01 is 16-bit
// - timer 1 select set counts pin falls, clear counts its selected clock
`ifndef CTU_PARAMS_SVH
`define CTU_PARAMS_SVH

`define CTU_SYSDIV12 4'hb
`define CTU_SYSDIV4 2'h3
`define CTU_DIV48_STEPS 2'h3
`define CTU_EXTDIV8 3'h7
`define CTU_SYSDIV2 1'h1
`define CTU_BYTE_MAX 8'hff
`define CTU_WORD_MAX 16'hffff
`define CTU_PIN_TIMER0_GATE_CONTROL 0
`define CTU_PIN_TIMER1_GATE_CONTROL 1
`define CTU_PIN_EVENT0 2
`define CTU_PIN_EVENT1 3
`define CTU_PIN_AREVT 4
`define CTU_PIN_ARCAP 6
`define CTU_PIN_EXTOSC 8
`define CTU_PIN_COUNT 9

`endif

//--- ctu_pkg.sv
/*
 Types of the counter/timer unit. Assumes nothing of its surroundings.
*/
package ctu_pkg;

    typedef enum logic [1:0] {
        CTU_MODE13 = 2'h0,
        CTU_MODE16 = 2'h1,
        CTU_MODE8R = 2'h2,
        CTU_MODESPLIT = 2'h3
    } ctu_mode_t;

    typedef enum logic [1:0] {
        CTU_PRE_DIV12 = 2'h0,
        CTU_PRE_DIV4 = 2'h1,
        CTU_PRE_DIV48 = 2'h2,
        CTU_PRE_EXT8 = 2'h3
    } ctu_prescale_t;

    typedef enum logic [1:0] {
        CTU_AR_DIV12 = 2'h0,
        CTU_AR_SYS = 2'h1,
        CTU_AR_EXT8 = 2'h2,
        CTU_AR_DIV2 = 2'h3
    } ctu_arsrc_t;

endpackage

//--- ctu_reload_timer.sv
/*
 One 16-bit auto-reload timer, optionally split into two 8-bit timers,
 with a capture register. Assumes one-cycle tick pulses.
*/
`timescale 1ns/1ns
`include "ctu_params.svh"

module ctu_reload_timer
    import ctu_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic tickLow,
    input wire logic tickHigh,
    input wire logic split,
    input wire logic loadEn,
    input wire logic [15:0] loadValue,
    input wire logic [15:0] reloadValue,
    input wire logic captureEvent,
    output logic [15:0] count,
    output logic [15:0] captureValue,
    output logic ovfLow,
    output logic ovfHigh
);

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count <= 16'h0000;
            ovfLow <= 1'b0;
            ovfHigh <= 1'b0;
        end
        else
        begin
            ovfLow <= 1'b0;
            ovfHigh <= 1'b0;
            if (loadEn)
            begin
                count <= loadValue;
            end
            else if (split)
            begin
                if (tickLow)
                begin
                    ovfLow <= (count[7:0] == `CTU_BYTE_MAX);
                    count[7:0] <= (count[7:0] == `CTU_BYTE_MAX) ? reloadValue[7:0]
                                                               : count[7:0] + 8'h01;
                end
                if (tickHigh)
                begin
                    ovfHigh <= (count[15:8] == `CTU_BYTE_MAX);
                    count[15:8] <= (count[15:8] == `CTU_BYTE_MAX) ? reloadValue[15:8]
                                                                 : count[15:8] + 8'h01;
                end
            end
            else if (tickLow)
            begin
                ovfLow <= (count == `CTU_WORD_MAX);
                count <= (count == `CTU_WORD_MAX) ? reloadValue : count + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            captureValue <= 16'h0000;
        end
        else if (captureEvent)
        begin
            captureValue <= count;
        end
    end

endmodule

//--- ctu_counter_timer_unit.sv
/*
 Six 16-bit counter/timers: two classic timers with four modes and four
 auto-reload timers. Assumes pins synchronous to mclk and that
 control bits come from registers elsewhere; flags are cleared by a pulse.
*/
`timescale 1ns/1ns
`include "ctu_params.svh"

module ctu_counter_timer_unit
    import ctu_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [1:0] prescaleField,
    input wire logic extOscIn,
    input wire logic timer0RunBit,
    input wire logic timer1RunBit,
    input wire logic timer0GateControl,
    input wire logic timer1GateControl,
    input wire logic timer0CounterSelect,
    input wire logic timer1CounterSelect,
    input wire logic timer0ClockSelect,
    input wire logic timer1ClockSelect,
    input wire logic [1:0] timer0ModeField,
    input wire logic [1:0] timer1ModeField,
    input wire logic gate0Pin,
    input wire logic gate1Pin,
    input wire logic event0Pin,
    input wire logic event1Pin,
    input wire logic timer0Load,
    input wire logic [15:0] timer0LoadValue,
    input wire logic timer1Load,
    input wire logic [15:0] timer1LoadValue,
    input wire logic timer0FlagClear,
    input wire logic timer1FlagClear,
    input wire logic [3:0] arRun,
    input wire logic [1:0] arRunHigh,
    input wire logic [1:0] arSplit,
    input wire logic [3:0][1:0] arClockSelect,
    input wire logic [1:0] arCounterSelect,
    input wire logic [1:0] arEventPin,
    input wire logic [1:0] arCapturePin,
    input wire logic [1:0] arToggleEnable,
    input wire logic [3:0][15:0] arReload,
    input wire logic [3:0] arLoad,
    input wire logic [3:0][15:0] arLoadValue,
    output logic [15:0] timer0Count,
    output logic [15:0] timer1Count,
    output logic timer0OverflowFlag,
    output logic timer1OverflowFlag,
    output logic timer1OverflowTick,
    output logic [3:0][15:0] arCount,
    output logic [1:0][15:0] arCapture,
    output logic [3:0] arOverflowLow,
    output logic [1:0] arOverflowHigh,
    output logic [1:0] toggleOut
);

    // one step of a classic timer: {overflow, next count}
    function automatic logic [16:0] classicStep(input logic [1:0] mode, input logic [15:0] v);
        logic [13:0] sum13;
        logic [16:0] sum16;
        sum13 = {1'b0, v[15:8], v[4:0]} + 14'h0001;
        sum16 = {1'b0, v} + 17'h0_0001;
        unique case (mode)
            CTU_MODE13: classicStep = {sum13[13], sum13[12:5], v[7:5], sum13[4:0]};
            CTU_MODE16: classicStep = sum16;
            CTU_MODE8R: classicStep = (v[7:0] == `CTU_BYTE_MAX)
                                      ? {1'b1, v[15:8], v[15:8]}
                                      : {1'b0, v[15:8], v[7:0] + 8'h01};
            CTU_MODESPLIT: classicStep = {1'b0, v};
        endcase
    endfunction

    // tick of an auto-reload timer from its clock-source code
    function automatic logic arSourceTick(input logic [1:0] sel, input logic allowDiv2,
                                          input logic t12, input logic t2, input logic tExt);
        unique case (sel)
            CTU_AR_DIV12: arSourceTick = t12;
            CTU_AR_SYS: arSourceTick = 1'b1;
            CTU_AR_EXT8: arSourceTick = tExt;
            CTU_AR_DIV2: arSourceTick = allowDiv2 ? t2 : 1'b1;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // two flops to settle, a third for edge detection
    logic [`CTU_PIN_COUNT-1:0] pinRaw;
    logic [`CTU_PIN_COUNT-1:0] pinMeta;
    logic [`CTU_PIN_COUNT-1:0] pinLevel;
    logic [`CTU_PIN_COUNT-1:0] pinLast;
    logic [`CTU_PIN_COUNT-1:0] pinFall;

    assign pinRaw = {extOscIn, arCapturePin, arEventPin, event1Pin, event0Pin,
                     gate1Pin, gate0Pin};

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pinMeta <= '0;
            pinLevel <= '0;
            pinLast <= '0;
        end
        else
        begin
            pinMeta <= pinRaw;
            pinLevel <= pinMeta;
            pinLast <= pinLevel;
        end
    end

    // a level held two clocks always lands in pinLevel, so fs/4 events survive
    assign pinFall = pinLast & ~pinLevel;

    ////////////////////////////////////////////////////////////////////////////////
    // shared dividers
    logic [3:0] div12Count;
    logic [1:0] div4Count;
    logic [1:0] div48Count;
    logic [2:0] ext8Count;
    logic div2Phase;
    logic tick12;
    logic tick4;
    logic tick48;
    logic tickExt8;
    logic preTick;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div12Count <= 4'h0;
            div4Count <= 2'h0;
            div2Phase <= 1'b0;
        end
        else
        begin
            div12Count <= (div12Count == `CTU_SYSDIV12) ? 4'h0 : div12Count + 4'h1;
            div4Count <= div4Count + 2'h1;
            div2Phase <= div2Phase + `CTU_SYSDIV2;
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div48Count <= 2'h0;
        end
        else if (tick12)
        begin
            div48Count <= div48Count + 2'h1;
        end
    end

    // the oscillator is sampled, so it must run below a quarter of mclk
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ext8Count <= 3'h0;
        end
        else if (pinFall[`CTU_PIN_EXTOSC])
        begin
            ext8Count <= ext8Count + 3'h1;
        end
    end

    assign tick12 = (div12Count == `CTU_SYSDIV12);
    assign tick4 = (div4Count == `CTU_SYSDIV4);
    assign tick48 = tick12 && (div48Count == `CTU_DIV48_STEPS);
    assign tickExt8 = pinFall[`CTU_PIN_EXTOSC] && (ext8Count == `CTU_EXTDIV8);

    always_comb
    begin
        unique case (prescaleField)
            CTU_PRE_DIV12: preTick = tick12;
            CTU_PRE_DIV4: preTick = tick4;
            CTU_PRE_DIV48: preTick = tick48;
            CTU_PRE_EXT8: preTick = tickExt8;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // classic timers 0 and 1
    logic splitMode;
    logic timer0Enabled;
    logic timer1Enabled;
    logic timer0Source;
    logic timer1Source;
    logic timeBase0;
    logic timer1Run;
    logic timer1Step;
    logic highStep;
    logic [16:0] next_timer0;
    logic [16:0] next_timer1;
    logic [8:0] next_low0;
    logic [8:0] next_high0;
    logic timer0Overflow;
    logic timer1FlagSet;

    assign splitMode = (timer0ModeField == CTU_MODESPLIT);
    assign timer0Enabled = timer0RunBit
                           && (!timer0GateControl || pinLevel[`CTU_PIN_TIMER0_GATE_CONTROL]);
    assign timer1Enabled = timer1RunBit
                           && (!timer1GateControl || pinLevel[`CTU_PIN_TIMER1_GATE_CONTROL]);
    assign timeBase0 = timer0ClockSelect ? 1'b1 : preTick;
    assign timer0Source = timer0CounterSelect ? pinFall[`CTU_PIN_EVENT0] : timeBase0;
    // in split mode the pin path is cut off
    assign timer1Source = (timer1CounterSelect && !splitMode)
                          ? pinFall[`CTU_PIN_EVENT1]
                          : (timer1ClockSelect ? 1'b1 : preTick);
    // in split mode only the mode field starts and stops timer 1
    assign timer1Run = (timer1ModeField != CTU_MODESPLIT)
                       && (splitMode || timer1Enabled);
    assign timer1Step = timer1Run && timer1Source;
    assign highStep = splitMode && timer1RunBit && timeBase0;

    assign next_timer0 = classicStep(timer0ModeField, timer0Count);
    assign next_timer1 = classicStep(timer1ModeField, timer1Count);
    assign next_low0 = {1'b0, timer0Count[7:0]} + 9'h001;
    assign next_high0 = {1'b0, timer0Count[15:8]} + 9'h001;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            timer0Count <= 16'h0000;
        end
        else if (timer0Load)
        begin
            timer0Count <= timer0LoadValue;
        end
        else if (splitMode)
        begin
            if (timer0Enabled && timer0Source)
            begin
                timer0Count[7:0] <= next_low0[7:0];
            end
            if (highStep)
            begin
                timer0Count[15:8] <= next_high0[7:0];
            end
        end
        else if (timer0Enabled && timer0Source)
        begin
            timer0Count <= next_timer0[15:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            timer1Count <= 16'h0000;
        end
        else if (timer1Load)
        begin
            timer1Count <= timer1LoadValue;
        end
        else if (timer1Step)
        begin
            timer1Count <= next_timer1[15:0];
        end
    end

    assign timer0Overflow = timer0Enabled && timer0Source && !timer0Load
                            && (splitMode ? next_low0[8] : next_timer0[16]);
    assign timer1FlagSet = splitMode
                           ? (highStep && next_high0[8] && !timer0Load)
                           : (timer1Step && next_timer1[16] && !timer1Load);

    // a set arriving with the clear pulse wins
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            timer0OverflowFlag <= 1'b0;
        end
        else
        begin
            timer0OverflowFlag <= timer0Overflow || (timer0OverflowFlag && !timer0FlagClear);
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            timer1OverflowFlag <= 1'b0;
        end
        else
        begin
            timer1OverflowFlag <= timer1FlagSet || (timer1OverflowFlag && !timer1FlagClear);
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            timer1OverflowTick <= 1'b0;
        end
        else
        begin
            timer1OverflowTick <= timer1Step && next_timer1[16] && !timer1Load;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // reload timers: index 0..1 are timers 2/3, 2..3 timers 4/5
    logic [3:0] arTick;
    logic [1:0] arHighTick;
    logic [1:0][15:0] arCaptureUnused;

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            arTick[i] = arRun[i] && arSourceTick(arClockSelect[i], (i >= 2),
                                                 tick12, div2Phase, tickExt8);
        end
        for (int i = 0; i < 2; i++)
        begin
            if (arCounterSelect[i])
            begin
                arTick[i + 2] = arRun[i + 2] && pinFall[`CTU_PIN_AREVT + i];
            end
            arHighTick[i] = arRunHigh[i] && arSourceTick(arClockSelect[i], 1'b0,
                                                         tick12, div2Phase, tickExt8);
        end
    end

    for (genvar g = 0; g < 4; g++)
    begin : gen_ar
        if (g < 2)
        begin : gen_split
            ctu_reload_timer u_timer (
                .mclk(mclk),
                .rst_b(rst_b),
                .tickLow(arTick[g]),
                .tickHigh(arHighTick[g]),
                .split(arSplit[g]),
                .loadEn(arLoad[g]),
                .loadValue(arLoadValue[g]),
                .reloadValue(arReload[g]),
                .captureEvent(1'b0),
                .count(arCount[g]),
                .captureValue(arCaptureUnused[g]),
                .ovfLow(arOverflowLow[g]),
                .ovfHigh(arOverflowHigh[g])
            );
        end
        else
        begin : gen_capture
            ctu_reload_timer u_timer (
                .mclk(mclk),
                .rst_b(rst_b),
                .tickLow(arTick[g]),
                .tickHigh(1'b0),
                .split(1'b0),
                .loadEn(arLoad[g]),
                .loadValue(arLoadValue[g]),
                .reloadValue(arReload[g]),
                .captureEvent(pinFall[`CTU_PIN_ARCAP + g - 2]),
                .count(arCount[g]),
                .captureValue(arCapture[g - 2]),
                .ovfLow(arOverflowLow[g]),
                .ovfHigh()
            );
        end
    end

    // every overflow flips the pin, giving a 50% square wave
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            toggleOut <= 2'h0;
        end
        else
        begin
            toggleOut <= toggleOut ^ (arToggleEnable & arOverflowLow[3:2]);
        end
    end

endmodule

//--- ctu_event_source.sv
/*
 Event pin model for the counter inputs.
 Assumes burst is called after a clock edge.
*/
`timescale 1ns/1ns
module ctu_event_source (
    input wire logic mclk,
    output logic pin
);
    // idles high: no false event
    initial pin = 1'b1;
    // each level stands hold edges; 2 is the fastest legal
    task automatic burst(input int n, input int hold);
        repeat (n)
        begin
            @(posedge mclk);
            pin <= 1'b0;
            repeat (hold) @(posedge mclk);
            pin <= 1'b1;
            repeat (hold - 1) @(posedge mclk);
        end
    endtask
endmodule

//--- ctu_counter_timer_unit_checker.sv
/*
 Assertions on the classic timers.
 Bound to the unit; sees its ports only.
*/
`timescale 1ns/1ns
module ctu_counter_timer_unit_checker
    import ctu_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic timer0RunBit,
    input wire logic timer1RunBit,
    input wire logic timer0GateControl,
    input wire logic timer0CounterSelect,
    input wire logic timer0ClockSelect,
    input wire logic timer1ClockSelect,
    input wire logic [1:0] timer0ModeField,
    input wire logic [1:0] timer1ModeField,
    input wire logic timer0Load,
    input wire logic [15:0] timer0LoadValue,
    input wire logic timer1Load,
    input wire logic [15:0] timer0Count,
    input wire logic [15:0] timer1Count,
    input wire logic timer0OverflowFlag,
    input wire logic timer1OverflowFlag,
    input wire logic timer1OverflowTick
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////
    logic split;
    logic t0Step;
    assign split = timer0ModeField == CTU_MODESPLIT;
    // prescaled ticks have a free phase; only mclk steps are checked
    assign t0Step = timer0RunBit && !timer0GateControl && timer0ClockSelect
        && !timer0CounterSelect && !timer0Load;
    ////////////////////////////////////////////////
    AST_T0_LOAD: assert property (timer0Load |=> timer0Count == $past(timer0LoadValue))
        else $error("t0 load lost");
    AST_T0_INC: assert property (
        t0Step && timer0ModeField == CTU_MODE16 && timer0Count != 16'hffff
        |=> timer0Count == $past(timer0Count) + 16'h0001)
        else $error("t0 step wrong");
    AST_T0_WRAP: assert property (
        t0Step && timer0ModeField == CTU_MODE16 && timer0Count == 16'hffff
        |=> timer0Count == 16'h0000 && timer0OverflowFlag)
        else $error("t0 wrap wrong");
    AST_T0_RELOAD: assert property (
        t0Step && timer0ModeField == CTU_MODE8R && timer0Count[7:0] == 8'hff
        |=> timer0Count[7:0] == timer0Count[15:8] && $stable(timer0Count[15:8])
        && timer0OverflowFlag)
        else $error("t0 reload wrong");
    AST_T0_HOLD: assert property (
        !split && !timer0RunBit && !timer0Load |=> $stable(timer0Count))
        else $error("t0 moved while stopped");
    AST_SPLIT_LOW: assert property (
        split && t0Step && timer0Count[7:0] == 8'hff
        |=> timer0Count[7:0] == 8'h00 && timer0OverflowFlag)
        else $error("split low wrap wrong");
    AST_SPLIT_HIGH: assert property (
        split && !timer1RunBit && !timer0Load |=> $stable(timer0Count[15:8]))
        else $error("split high ran without run bit");
    AST_T1_NOFLAG: assert property (
        split && !timer1OverflowFlag && timer0Count[15:8] != 8'hff && !timer0Load
        |=> !timer1OverflowFlag)
        else $error("t1 flag set in split");
    AST_T1_TICK: assert property (
        split && timer1ModeField == CTU_MODE16 && timer1ClockSelect
        && timer1Count == 16'hffff && !timer1Load
        |=> timer1OverflowTick && timer1Count == 16'h0000)
        else $error("t1 tick missing in split");
    AST_T1_STOP: assert property (
        split && timer1ModeField == CTU_MODESPLIT && !timer1Load |=> $stable(timer1Count))
        else $error("t1 ran in mode 3");
endmodule

bind ctu_counter_timer_unit ctu_counter_timer_unit_checker u_chk (.*);

//--- tb_ctu_counter_timer_unit.sv
/*
 Bench: classic timer table, then split, counter, reload, reset cases.
 Assumes the checker is bound in.
*/
`timescale 1ns/1ns
module tb_ctu_counter_timer_unit
    import ctu_pkg::*;
();
    typedef struct packed {
        logic [1:0] mode;
        logic gc;
        logic [15:0] ld;
        logic [3:0] n;
        logic [15:0] cnt;
        logic flg;
    } ctu_row_t;
    localparam ctu_row_t ROWS [8] = '{
        '{CTU_MODE16, 1'b0, 16'hfffe, 4'h2, 16'h0000, 1'b1},
        '{CTU_MODE16, 1'b0, 16'h1234, 4'h5, 16'h1239, 1'b0},
        '{CTU_MODE16, 1'b1, 16'h0010, 4'h4, 16'h0010, 1'b0},
        '{CTU_MODE13, 1'b0, 16'h001f, 4'h1, 16'h0100, 1'b0},
        '{CTU_MODE13, 1'b0, 16'h00ff, 4'h1, 16'h01e0, 1'b0},
        '{CTU_MODE13, 1'b0, 16'hff1f, 4'h1, 16'h0000, 1'b1},
        '{CTU_MODE8R, 1'b0, 16'h40fe, 4'h3, 16'h4041, 1'b1},
        '{CTU_MODE8R, 1'b0, 16'h40fd, 4'h1, 16'h40fe, 1'b0}};
    logic mclk, rst_b, extOscIn, timer0RunBit, timer1RunBit, tog;
    logic timer0GateControl, timer1GateControl, timer0CounterSelect, timer1CounterSelect;
    logic timer0ClockSelect, timer1ClockSelect, gate0Pin, gate1Pin, event0Pin, event1Pin;
    logic timer0Load, timer1Load, timer0FlagClear, timer1FlagClear;
    logic timer0OverflowFlag, timer1OverflowFlag, timer1OverflowTick;
    logic [1:0] prescaleField, timer0ModeField, timer1ModeField, arRunHigh, arSplit, oscDiv;
    logic [1:0] arCounterSelect, arEventPin, arCapturePin, arToggleEnable;
    logic [1:0] arOverflowHigh, toggleOut;
    logic [15:0] timer0LoadValue, timer1LoadValue, timer0Count, timer1Count;
    logic [3:0] arRun, arLoad, arOverflowLow;
    logic [3:0][1:0] arClockSelect;
    logic [3:0][15:0] arReload, arLoadValue, arCount;
    logic [1:0][15:0] arCapture;
    int nFail, numChecks;
    ////////////////////////////////////////////////
    ctu_counter_timer_unit dut (.*);
    ctu_event_source src0 (.mclk, .pin(event0Pin));
    ctu_event_source src1 (.mclk, .pin(event1Pin));
    assign arEventPin = {event1Pin, event0Pin};
    assign arCapturePin = {event0Pin, event1Pin};
    ////////////////////////////////////////////////
    always #4 mclk = ~mclk;
    // oscillator of six mclk periods, under a quarter of mclk
    always @(posedge mclk)
    begin
        oscDiv <= (oscDiv == 2'h2) ? 2'h0 : oscDiv + 2'h1;
        if (oscDiv == 2'h2)
            extOscIn <= ~extOscIn;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        numChecks++;
        if (got !== exp)
        begin
            nFail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ld(input logic [15:0] v0, input logic [15:0] v1);
        @(posedge mclk);
        timer0LoadValue <= v0;
        timer1LoadValue <= v1;
        {timer0Load, timer1Load, timer0FlagClear, timer1FlagClear} <= 4'hf;
        @(posedge mclk);
        {timer0Load, timer1Load, timer0FlagClear, timer1FlagClear} <= 4'h0;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic summarize();
        if (nFail == 0 && numChecks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////
    initial
    begin
        {mclk, rst_b, extOscIn, oscDiv, timer0RunBit, timer1RunBit, timer0GateControl,
            timer1GateControl, timer0CounterSelect, timer1CounterSelect, timer0ClockSelect,
            timer1ClockSelect, gate0Pin, gate1Pin, timer0Load, timer1Load, timer0FlagClear,
            timer1FlagClear, prescaleField, timer0ModeField, timer1ModeField} = '0;
        {arRunHigh, arSplit, arCounterSelect, arToggleEnable, arRun, arLoad} = '0;
        {timer0LoadValue, timer1LoadValue, arClockSelect, arReload, arLoadValue} = '0;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        tick(1);
        chk("t0 count at reset", 16'h0000, timer0Count);
        chk("t1 flag at reset", 16'h0000, 16'(timer1OverflowFlag));
        @(posedge mclk);
        {timer0RunBit, timer1RunBit, timer0ClockSelect, timer1ClockSelect} <= 4'hf;
        foreach (ROWS[i])
        begin
            @(posedge mclk);
            {timer0ModeField, timer1ModeField} <= {ROWS[i].mode, ROWS[i].mode};
            {timer0GateControl, timer1GateControl} <= {ROWS[i].gc, ROWS[i].gc};
            ld(ROWS[i].ld, ROWS[i].ld);
            tick(ROWS[i].n);
            chk("t0 count", ROWS[i].cnt, timer0Count);
            chk("t0 flag", 16'(ROWS[i].flg), 16'(timer0OverflowFlag));
            chk("t1 count", ROWS[i].cnt, timer1Count);
        end
        @(posedge mclk);
        {timer0ModeField, prescaleField, timer0ClockSelect} <= {CTU_MODE16, CTU_PRE_DIV4, 1'b0};
        ld(16'h0000, 16'h0000);
        tick(40);
        chk("t0 prescaled", 16'h0001,
            16'(timer0Count >= 16'h0009 && timer0Count <= 16'h000b));
        @(posedge mclk);
        {timer0ModeField, timer1ModeField, timer0ClockSelect, timer1CounterSelect}
            <= {CTU_MODESPLIT, CTU_MODE16, 2'h3};
        ld(16'h10fe, 16'hfffe);
        tick(2);
        chk("split count", 16'h1200, timer0Count);
        chk("split t0 flag", 16'h0001, 16'(timer0OverflowFlag));
        chk("t1 tick", 16'h0001, 16'(timer1OverflowTick));
        chk("t1 split count", 16'h0000, timer1Count);
        chk("t1 split flag", 16'h0000, 16'(timer1OverflowFlag));
        ld(16'hff00, 16'h0000);
        tick(1);
        chk("high wrap", 16'h0001, timer0Count);
        chk("t1 flag by high", 16'h0001, 16'(timer1OverflowFlag));
        @(posedge mclk);
        {timer1RunBit, timer1ModeField} <= {1'b0, CTU_MODESPLIT};
        tick(3);
        chk("high held", 16'h0105, timer0Count);
        chk("t1 stopped", 16'h0002, timer1Count);
        @(posedge mclk);
        timer1ModeField <= CTU_MODE16;
        tick(2);
        chk("t1 runs", 16'h0004, timer1Count);
        @(posedge mclk);
        {timer0ModeField, timer1RunBit, timer0CounterSelect, gate0Pin} <= {CTU_MODE16, 3'h7};
        arCounterSelect <= 2'h3;
        ld(16'h0000, 16'h0000);
        fork
            src0.burst(5, 2);
            src1.burst(3, 3);
        join
        tick(4);
        chk("t0 events", 16'h0005, timer0Count);
        chk("t1 events", 16'h0003, timer1Count);
        @(posedge mclk);
        arClockSelect <= {4{CTU_AR_SYS}};
        arReload <= {16'hfffe, 16'hfffe, 16'h2030, 16'h1000};
        arLoadValue <= {4{16'hfffe}};
        {arRun, arLoad, arSplit, arRunHigh, arToggleEnable, arCounterSelect} <= {8'hff, 8'hfc};
        @(posedge mclk);
        arLoad <= 4'h0;
        tick(3);
        chk("t2 reload", 16'h1201, arCount[0]);
        tog = toggleOut[0];
        tick(2);
        chk("t4 toggle", {15'h0000, ~tog}, {15'h0000, toggleOut[0]});
        @(posedge mclk);
        rst_b <= 1'b0;
        tick(2);
        chk("t0 mid reset", 16'h0000, timer0Count);
        chk("toggle mid reset", 16'h0000, 16'(toggleOut));
        @(posedge mclk);
        rst_b <= 1'b1;
        tick(2);
        summarize();
    end
    initial
    begin
        repeat (2000) @(posedge mclk);
        nFail++;
        summarize();
    end
endmodule
